// >>> hw/itc_pkg.sv
/*
 * Shared constants and types of the transfer controller: descriptor layout,
 * mode word fields, register offsets and the system bus request carrier.
 * Assumes a 32-bit system bus that answers every request with one ack.
 */
package itc_pkg;

	localparam int          NUM_SRC        = 8;
	localparam int          SRC_W          = 3;
	localparam logic [31:0] VEC_TABLE_BASE = 32'h0000_0400;
	localparam logic [31:0] VEC_ENTRY_SIZE = 32'h0000_0002;
	localparam logic [31:0] DESC_STRIDE    = 32'h0000_0010;
	localparam logic [31:0] DESC_WORD_SIZE = 32'h0000_0004;

	localparam logic [1:0]  DESC_RD_LAST   = 2'h3;
	localparam logic [1:0]  DESC_WB_LAST   = 2'h2;
	localparam logic [1:0]  DESC_IDX_MODE  = 2'h0;
	localparam logic [1:0]  DESC_IDX_AUX   = 2'h1;
	localparam logic [1:0]  DESC_IDX_SRC   = 2'h2;
	localparam logic [1:0]  DESC_IDX_DST   = 2'h3;

	localparam int MW_SM_HI = 15;
	localparam int MW_SM_LO = 14;
	localparam int MW_DM_HI = 13;
	localparam int MW_DM_LO = 12;
	localparam int MW_MD_HI = 11;
	localparam int MW_MD_LO = 10;
	localparam int MW_SZ_HI = 9;
	localparam int MW_SZ_LO = 8;
	localparam int MW_AREA  = 7;
	localparam int MW_CHAIN = 6;
	localparam int MW_ISEL  = 5;

	localparam logic [1:0] MD_NORMAL = 2'h0;
	localparam logic [1:0] MD_REPEAT = 2'h1;
	localparam logic [1:0] MD_BLOCK  = 2'h2;
	localparam logic [1:0] SZ_BYTE   = 2'h0;
	localparam logic [1:0] SZ_WORD   = 2'h1;
	localparam logic [1:0] SZ_LONG   = 2'h2;
	localparam logic [1:0] AM_INC    = 2'h2;
	localparam logic [1:0] AM_DEC    = 2'h3;

	localparam logic [11:0] REG_BASE   = 12'h000;
	localparam logic [11:0] REG_ENABLE = 12'h004;
	localparam logic [11:0] REG_SWCTL  = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00C;
	localparam int          SW_FLAG    = 8;
	localparam int          SW_DONE    = 9;

	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [7:0]  LOW_ONE   = 8'h01;
	localparam logic [16:0] BLK_ONE   = 17'h0_0001;
	localparam logic [16:0] BLK_FULL  = 17'h1_0000;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} itc_bus_req_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_VEC     = 4'b0001,
		ST_DESC_RD = 4'b0010,
		ST_INT_OP  = 4'b0011,
		ST_DATA_RD = 4'b0100,
		ST_DATA_WR = 4'b0101,
		ST_DESC_WB = 4'b0110,
		ST_FINISH  = 4'b0111
	} itc_state_t;

	// Byte distance of one transfer unit.
	function automatic logic [31:0] itc_unit_bytes(input logic [1:0] sz);
		if (sz == SZ_LONG) begin
			return 32'h0000_0004;
		end else if (sz == SZ_WORD) begin
			return 32'h0000_0002;
		end else begin
			return 32'h0000_0001;
		end
	endfunction

	// Block length, with zero standing for the full 65536.
	function automatic logic [16:0] itc_block_len(input logic [15:0] len);
		if (len == 16'h0000) begin
			return BLK_FULL;
		end else begin
			return {1'b0, len};
		end
	endfunction

endpackage

// >>> hw/itc_addr_step.sv
/*
 * Address stepper: next source or destination address after one unit.
 * Assumes mode bits straight from the mode word; purely combinational.
 */
`timescale 1ns/1ps
module itc_addr_step
	import itc_pkg::*;
(
	// Current address and how it moves.
	input  wire logic [31:0] addr,
	input  wire logic [1:0]  step_mode,
	input  wire logic [1:0]  unit_size,
	// Address after the step.
	output logic      [31:0] next_addr
);

	always_comb begin
		if (step_mode == AM_INC) begin
			next_addr = addr + itc_unit_bytes(unit_size); // [RULE22]
		end else if (step_mode == AM_DEC) begin
			next_addr = addr - itc_unit_bytes(unit_size); // [RULE22]
		end else begin
			next_addr = addr;
		end
	end

endmodule

// >>> hw/itc_apb_decode.sv
/*
 * APB slave front end: zero-wait answer, address decode, write strobes and
 * the read multiplexer. Assumes register contents are held by the parent.
 */
`timescale 1ns/1ps
module itc_apb_decode
	import itc_pkg::*;
(
	// APB slave side.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] prdata,
	// Register images for reads.
	input  wire logic [31:0] rd_base,
	input  wire logic [31:0] rd_enable,
	input  wire logic [31:0] rd_swctl,
	input  wire logic [31:0] rd_status,
	// One-cycle write strobes at the completing edge.
	output logic             wr_base,
	output logic             wr_enable,
	output logic             wr_swctl
);

	logic access;
	logic mapped;

	assign access = psel & penable;
	assign pready = 1'b1;

	always_comb begin
		mapped = 1'b1;
		prdata = 32'h0000_0000;
		if (paddr == REG_BASE) begin
			prdata = rd_base;
		end else if (paddr == REG_ENABLE) begin
			prdata = rd_enable;
		end else if (paddr == REG_SWCTL) begin
			prdata = rd_swctl;
		end else if (paddr == REG_STATUS) begin
			prdata = rd_status;
		end else begin
			mapped = 1'b0;
		end
	end

	assign pslverr   = access & ~mapped;
	assign wr_base   = access & pwrite & (paddr == REG_BASE);
	assign wr_enable = access & pwrite & (paddr == REG_ENABLE);
	assign wr_swctl  = access & pwrite & (paddr == REG_SWCTL);

endmodule

// >>> hw/itc_transfer_controller.sv
/*
 * Transfer controller core: activation by interrupt sources or software,
 * vector fetch, descriptor read, data moves, descriptor write-back and the
 * end-of-activation actions. Assumes sources are same-clock levels and the
 * system bus holds each request until it returns one ack pulse.
 */
`timescale 1ns/1ps
// Contract
// [RULE1] Normal mode writes back mode, count-1, stepped addresses.
// [RULE2] Normal count 1..65536, interrupt after count one.
// [RULE3] Repeat mode moves one unit per activation.
// [RULE4] Repeat low byte decrements, reloads from hold byte.
// [RULE5] Repeat expiry restores area address from initial.
// [RULE6] Repeat with select clear never interrupts.
// [RULE7] Block mode moves whole block, restores area.
// [RULE8] Block count 1..65536, interrupt after count one.
// [RULE9] Block writes count-1, never block length.
// [RULE10] Descriptor read four accesses, write-back three.
// [RULE11] Vector, seven descriptor, internal, data accesses.
// [RULE12] Access length set by the answering target.
// [RULE13] Chain enable runs further descriptors same activation.
// [RULE14] Software prepares descriptors, base, enable bits.
// [RULE15] Clear source or enable depending on interrupt.
// [RULE16] Software checks activation flag is zero first.
// [RULE17] Software writes flag and vector together.
// [RULE18] Flag cleared, or held for interrupt routine.
// [RULE19] Descriptor address: base high, vector low.
// [RULE20] Software vector at table base plus number.
// [RULE21] Normal descriptor order; unused word ignored.
// [RULE22] Addresses step by unit size.
module itc_transfer_controller
	import itc_pkg::*;
(
	// Clock and reset.
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB register port.
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic                     pready,
	output logic                     pslverr,
	output logic      [31:0]         prdata,
	// Interrupt sources and their end-of-activation answers.
	input  wire logic [NUM_SRC-1:0]  src_request,
	output logic      [NUM_SRC-1:0]  src_clear,
	output logic      [NUM_SRC-1:0]  cpu_request,
	output logic                     software_done_interrupt,
	// System bus master.
	output itc_bus_req_t             sys_out,
	input  wire logic [31:0]         sys_rdata,
	input  wire logic                sys_ack
);

	itc_state_t state;
	logic [15:0]        descriptor_base;
	logic [NUM_SRC-1:0] source_transfer_enable;
	logic [7:0]         software_vector_number;
	logic               software_activation_flag;
	logic               sw_started;
	logic               act_sw;
	logic [SRC_W-1:0]   act_src;
	logic [1:0]         word_idx;
	logic [31:0]        desc_addr;
	logic [15:0]        mode_word;
	logic [15:0]        transfer_count;
	logic [31:0]        aux_word;
	logic [31:0]        source_address;
	logic [31:0]        destination_address;
	logic [31:0]        src_start;
	logic [31:0]        dst_start;
	logic [16:0]        blk_left;
	logic [31:0]        data_buf;
	logic               want_irq;

	logic               wr_base;
	logic               wr_enable;
	logic               wr_swctl;
	logic [31:0]        src_stepped;
	logic [31:0]        dst_stepped;
	logic [NUM_SRC-1:0] pending;
	logic [SRC_W-1:0]   pick;
	logic               pick_valid;
	logic               sw_start;
	logic [1:0]         md;
	logic [1:0]         sz;
	logic               area_select;
	logic               chain_enable;
	logic               interrupt_select;
	logic               unit_last;
	logic               count_expiring;
	logic               repeat_expiring;
	logic [15:0]        next_count;
	logic               finish_hw;

	assign md               = mode_word[MW_MD_HI:MW_MD_LO];
	assign sz               = mode_word[MW_SZ_HI:MW_SZ_LO];
	assign area_select      = mode_word[MW_AREA];
	assign chain_enable     = mode_word[MW_CHAIN];
	assign interrupt_select = mode_word[MW_ISEL];

	itc_apb_decode u_apb (
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pready    (pready),
		.pslverr   (pslverr),
		.prdata    (prdata),
		.rd_base   ({16'h0000, descriptor_base}),
		.rd_enable ({{(32-NUM_SRC){1'b0}}, source_transfer_enable}),
		.rd_swctl  ({22'h00_0000, software_done_interrupt, software_activation_flag,
			software_vector_number}),
		.rd_status ({27'h000_0000, (state != ST_IDLE), state}),
		.wr_base   (wr_base),
		.wr_enable (wr_enable),
		.wr_swctl  (wr_swctl)
	);

	itc_addr_step u_src_step (
		.addr      (source_address),
		.step_mode (mode_word[MW_SM_HI:MW_SM_LO]),
		.unit_size (sz),
		.next_addr (src_stepped)
	);

	itc_addr_step u_dst_step (
		.addr      (destination_address),
		.step_mode (mode_word[MW_DM_HI:MW_DM_LO]),
		.unit_size (sz),
		.next_addr (dst_stepped)
	);

	// Lowest index wins among enabled, requesting sources.
	assign pending = src_request & source_transfer_enable;
	always_comb begin
		pick       = '0;
		pick_valid = 1'b0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i]) begin
				pick       = i[SRC_W-1:0];
				pick_valid = 1'b1;
			end
		end
	end
	assign sw_start = software_activation_flag & ~sw_started & ~pick_valid;

	// Last unit of this descriptor, and what the count does.
	assign unit_last       = (md != MD_BLOCK) || (blk_left == BLK_ONE); // [RULE3] [RULE7]
	assign count_expiring  = (transfer_count == COUNT_ONE);
	assign repeat_expiring = (transfer_count[7:0] == LOW_ONE);
	always_comb begin
		if (md == MD_REPEAT) begin
			if (repeat_expiring) begin
				next_count = {transfer_count[15:8], transfer_count[15:8]}; // [RULE4]
			end else begin
				next_count = {transfer_count[15:8], transfer_count[7:0] - LOW_ONE}; // [RULE4]
			end
		end else begin
			next_count = transfer_count - COUNT_ONE; // [RULE1] [RULE2] [RULE8] [RULE9]
		end
	end

	assign finish_hw  = (state == ST_FINISH) & ~act_sw;

	// Bus request, built from held state; held until the ack.
	always_comb begin
		sys_out = '0;
		case (state)
			ST_VEC: begin
				sys_out.req  = 1'b1;
				sys_out.size = SZ_WORD;
				if (act_sw) begin
					sys_out.addr = VEC_TABLE_BASE + {24'h00_0000, software_vector_number}; // [RULE20]
				end else begin
					sys_out.addr = VEC_TABLE_BASE + VEC_ENTRY_SIZE * {29'h0, act_src};
				end
			end
			ST_DESC_RD: begin
				sys_out.req  = 1'b1;
				sys_out.size = SZ_LONG;
				sys_out.addr = desc_addr + DESC_WORD_SIZE * {30'h0, word_idx}; // [RULE10] [RULE21]
			end
			ST_DATA_RD: begin
				sys_out.req  = 1'b1;
				sys_out.size = sz;
				sys_out.addr = source_address;
			end
			ST_DATA_WR: begin
				sys_out.req   = 1'b1;
				sys_out.we    = 1'b1;
				sys_out.size  = sz;
				sys_out.addr  = destination_address;
				sys_out.wdata = data_buf;
			end
			ST_DESC_WB: begin
				sys_out.req  = 1'b1;
				sys_out.we   = 1'b1;
				sys_out.size = SZ_LONG;
				// Word one (unused, initial address or block length) is skipped.
				if (word_idx == DESC_IDX_MODE) begin
					sys_out.addr  = desc_addr;
					sys_out.wdata = {mode_word, transfer_count}; // [RULE1] [RULE9]
				end else if (word_idx == DESC_IDX_AUX) begin
					sys_out.addr  = desc_addr + DESC_WORD_SIZE * {30'h0, DESC_IDX_SRC};
					sys_out.wdata = source_address;
				end else begin
					sys_out.addr  = desc_addr + DESC_WORD_SIZE * {30'h0, DESC_IDX_DST};
					sys_out.wdata = destination_address;
				end
			end
			default: begin
				sys_out = '0;
			end
		endcase
	end

	// Activation sequence; every bus state waits for the target's ack.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= ST_IDLE;
			word_idx <= 2'h0;
			act_sw   <= 1'b0;
			act_src  <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					word_idx <= 2'h0;
					if (pick_valid) begin
						act_sw  <= 1'b0;
						act_src <= pick;
						state   <= ST_VEC;
					end else if (sw_start) begin
						act_sw <= 1'b1;
						state  <= ST_VEC;
					end
				end
				ST_VEC: begin
					if (sys_ack) begin
						state <= ST_DESC_RD; // [RULE11]
					end
				end
				ST_DESC_RD: begin
					if (sys_ack) begin
						word_idx <= word_idx + 2'h1;
						if (word_idx == DESC_RD_LAST) begin
							state <= ST_INT_OP; // [RULE10]
						end
					end
				end
				ST_INT_OP: begin
					state <= ST_DATA_RD; // [RULE11]
				end
				ST_DATA_RD: begin
					if (sys_ack) begin
						state <= ST_DATA_WR; // [RULE12]
					end
				end
				ST_DATA_WR: begin
					if (sys_ack) begin
						word_idx <= 2'h0;
						state    <= unit_last ? ST_DESC_WB : ST_DATA_RD; // [RULE7]
					end
				end
				ST_DESC_WB: begin
					if (sys_ack) begin
						word_idx <= word_idx + 2'h1;
						if (word_idx == DESC_WB_LAST) begin
							word_idx <= 2'h0;
							state    <= chain_enable ? ST_DESC_RD : ST_FINISH; // [RULE13]
						end
					end
				end
				ST_FINISH: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Descriptor address and the descriptor fields.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			desc_addr      <= 32'h0000_0000;
			mode_word      <= 16'h0000;
			transfer_count <= 16'h0000;
			aux_word       <= 32'h0000_0000;
		end else if (state == ST_VEC && sys_ack) begin
			desc_addr <= {descriptor_base, sys_rdata[15:0]}; // [RULE19]
		end else if (state == ST_DESC_WB && sys_ack && word_idx == DESC_WB_LAST) begin
			desc_addr <= desc_addr + DESC_STRIDE; // [RULE13]
		end else if (state == ST_DESC_RD && sys_ack) begin
			if (word_idx == DESC_IDX_MODE) begin
				mode_word      <= sys_rdata[31:16];
				transfer_count <= sys_rdata[15:0];
			end else if (word_idx == DESC_IDX_AUX) begin
				aux_word <= sys_rdata; // [RULE21]
			end
		end else if (state == ST_DATA_WR && sys_ack && unit_last) begin
			transfer_count <= next_count; // [RULE4]
		end
	end

	// Addresses: step each unit, restore the chosen area when due.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_address      <= 32'h0000_0000;
			destination_address <= 32'h0000_0000;
			src_start           <= 32'h0000_0000;
			dst_start           <= 32'h0000_0000;
		end else if (state == ST_DESC_RD && sys_ack && word_idx == DESC_IDX_SRC) begin
			source_address <= sys_rdata;
			src_start      <= sys_rdata;
		end else if (state == ST_DESC_RD && sys_ack && word_idx == DESC_IDX_DST) begin
			destination_address <= sys_rdata;
			dst_start           <= sys_rdata;
		end else if (state == ST_DATA_WR && sys_ack) begin
			source_address      <= src_stepped; // [RULE1] [RULE22]
			destination_address <= dst_stepped; // [RULE1] [RULE22]
			if (md == MD_REPEAT && repeat_expiring) begin
				if (area_select) begin
					source_address <= aux_word; // [RULE5]
				end else begin
					destination_address <= aux_word; // [RULE5]
				end
			end else if (md == MD_BLOCK && unit_last) begin
				if (area_select) begin
					source_address <= src_start; // [RULE7]
				end else begin
					destination_address <= dst_start; // [RULE7]
				end
			end
		end
	end

	// Data holding register and the block unit counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_buf <= 32'h0000_0000;
			blk_left <= 17'h0_0000;
		end else if (state == ST_INT_OP) begin
			blk_left <= itc_block_len(aux_word[15:0]); // [RULE7]
		end else if (state == ST_DATA_RD && sys_ack) begin
			data_buf <= sys_rdata;
		end else if (state == ST_DATA_WR && sys_ack) begin
			blk_left <= blk_left - BLK_ONE;
		end
	end

	// CPU interrupt decision, gathered over a chain.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			want_irq <= 1'b0;
		end else if (state == ST_IDLE) begin
			want_irq <= 1'b0;
		end else if (state == ST_DATA_WR && sys_ack && unit_last) begin
			if (md == MD_REPEAT) begin
				want_irq <= want_irq | (interrupt_select & repeat_expiring); // [RULE6]
			end else begin
				want_irq <= want_irq | count_expiring; // [RULE2] [RULE8]
			end
		end
	end

	// End-of-activation answers to the interrupt sources.
	always_comb begin
		src_clear   = '0;
		cpu_request = '0;
		if (finish_hw) begin
			if (want_irq) begin
				cpu_request[act_src] = 1'b1; // [RULE15]
			end else begin
				src_clear[act_src] = 1'b1; // [RULE15]
			end
		end
	end

	// Descriptor base and per-source enables.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			descriptor_base        <= 16'h0000;
			source_transfer_enable <= '0;
		end else begin
			if (wr_base) begin
				descriptor_base <= pwdata[15:0];
			end
			if (wr_enable) begin
				source_transfer_enable <= pwdata[NUM_SRC-1:0];
			end else if (finish_hw && want_irq) begin
				source_transfer_enable[act_src] <= 1'b0; // [RULE15]
			end
		end
	end

	// Software activation flag, vector and done interrupt; a write wins for the flag, a finish that sets done wins over its clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			software_vector_number   <= 8'h00;
			software_activation_flag <= 1'b0;
			software_done_interrupt  <= 1'b0;
			sw_started               <= 1'b0;
		end else begin
			if (state == ST_IDLE && !pick_valid && sw_start) begin
				sw_started <= 1'b1;
			end else if (!software_activation_flag) begin
				sw_started <= 1'b0;
			end
			if (state == ST_FINISH && act_sw) begin
				sw_started              <= want_irq; // [RULE18]
				software_activation_flag <= want_irq; // [RULE18]
				software_done_interrupt <= want_irq; // [RULE18]
			end
			if (wr_swctl && pstrb[0]) begin
				software_vector_number <= pwdata[7:0]; // [RULE17]
			end
			if (wr_swctl && pstrb[1]) begin
				software_activation_flag <= pwdata[SW_FLAG]; // [RULE17]
				if (!pwdata[SW_FLAG] && !(state == ST_FINISH && act_sw && want_irq)) begin
					software_done_interrupt <= 1'b0; // [RULE18]
				end
			end
		end
	end

endmodule

// >>> sim/itc_transfer_controller_sva.sv
/* Checker of the transfer controller's bus order and end-of-activation answers.
 * Assumes it is bound to the core and sees only the core's ports. */
`timescale 1ns/1ps
module itc_transfer_controller_sva
	import itc_pkg::*;
(
	// Clock and reset.
	input wire logic               pclk,
	input wire logic               presetn,
	// Sources and their answers.
	input wire logic [NUM_SRC-1:0] src_request,
	input wire logic [NUM_SRC-1:0] src_clear,
	input wire logic [NUM_SRC-1:0] cpu_request,
	// System bus.
	input wire itc_bus_req_t       sys_out,
	input wire logic [31:0]        sys_rdata,
	input wire logic               sys_ack
);
	logic [1:0]         gap;
	logic               invec;
	logic [3:0]         acnt;
	logic [15:0]        vlo;
	logic               vec_now;
	logic [NUM_SRC-1:0] ends;

	assign vec_now = sys_out.req && (gap == 2'h2 || invec);
	assign ends    = src_clear | cpu_request;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap   <= 2'h2;
			invec <= 1'b0;
		end else begin
			gap   <= sys_out.req ? 2'h0 : (gap == 2'h2 ? 2'h2 : gap + 2'h1);
			invec <= vec_now && !sys_ack;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acnt <= 4'h0;
			vlo  <= 16'h0000;
		end else if (sys_ack) begin
			acnt <= vec_now ? 4'h1 : (acnt == 4'hF ? acnt : acnt + 4'h1);
			vlo  <= vec_now ? sys_rdata[15:0] : vlo;
		end
	end

	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	vec_fetch_a: assert property (
		vec_now |-> !sys_out.we && sys_out.size == SZ_WORD && sys_out.addr[31:8] == 24'h00_0004)
		else $error("vector fetch wrong");
	desc_base_a: assert property (
		sys_out.req && !vec_now && acnt == 4'h1 |-> sys_out.addr[15:0] == vlo)
		else $error("descriptor address wrong");
	desc_read_a: assert property (
		sys_out.req && !vec_now && acnt inside {[4'h1:4'h4]} |-> !sys_out.we
		&& sys_out.size == SZ_LONG && sys_out.addr[3:0] == {acnt[1:0] - 2'h1, 2'h0})
		else $error("descriptor read wrong");
	int_op_a: assert property (
		sys_ack && !vec_now && acnt == 4'h4 |=> !sys_out.req ##1 (sys_out.req && !sys_out.we))
		else $error("internal cycle missing");
	rd_wr_a: assert property (
		sys_ack && acnt == 4'h5 |=> sys_out.req && sys_out.we && sys_out.size == $past(sys_out.size))
		else $error("data write missing");
	req_hold_a: assert property (
		sys_out.req && !sys_ack |=> sys_out.req && $stable(sys_out))
		else $error("request dropped early");
	end_excl_a: assert property (
		(src_clear & cpu_request) == 8'h00)
		else $error("clear and interrupt together");
	end_src_a: assert property (
		|ends |-> $onehot(ends) && (ends & ~src_request) == 8'h00)
		else $error("end answer for idle source");
	end_idle_a: assert property (
		|ends |-> !sys_out.req ##1 !sys_out.req)
		else $error("bus busy at finish");
endmodule

bind itc_transfer_controller itc_transfer_controller_sva i_itc_transfer_controller_sva (
	.pclk(pclk), .presetn(presetn), .src_request(src_request), .src_clear(src_clear),
	.cpu_request(cpu_request), .sys_out(sys_out), .sys_rdata(sys_rdata), .sys_ack(sys_ack)
);

// >>> sim/itc_mem_model.sv
/* Behavioural system memory answering the controller's bus requests.
 * Assumes each request is held until its single ack pulse. */
`timescale 1ns/1ps
module itc_mem_model
	import itc_pkg::*;
(
	// Clock, reset and pacing.
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         slow,
	// Bus from the controller.
	input  wire itc_bus_req_t sys_out,
	output logic       [31:0] sys_rdata,
	output logic              sys_ack
);
	logic [31:0] mem [logic [29:0]];
	int          wait_cnt;

	// Merges one unit into its word, low lanes first.
	task automatic poke(input logic [31:0] a, input logic [1:0] sz, input logic [31:0] d);
		logic [31:0] m;
		m = (sz == SZ_LONG) ? 32'hFFFF_FFFF : (sz == SZ_WORD) ? 32'h0000_FFFF : 32'h0000_00FF;
		m = m << (8 * a[1:0]);
		if (!mem.exists(a[31:2])) begin
			mem[a[31:2]] = 32'h0000_0000;
		end
		mem[a[31:2]] = (mem[a[31:2]] & ~m) | ((d << (8 * a[1:0])) & m);
	endtask

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_ack   <= 1'b0;
			sys_rdata <= 32'h0000_0000;
			wait_cnt  <= 0;
		end else if (sys_out.req && !sys_ack && wait_cnt >= (slow ? 3 : 0)) begin
			sys_ack   <= 1'b1;
			wait_cnt  <= 0;
			sys_rdata <= mem[sys_out.addr[31:2]] >> (8 * sys_out.addr[1:0]);
			if (sys_out.we) begin
				poke(sys_out.addr, sys_out.size, sys_out.wdata);
			end
		end else begin
			sys_ack   <= 1'b0;
			sys_rdata <= ~sys_rdata;
			wait_cnt  <= sys_out.req ? wait_cnt + 1 : 0;
		end
	end
endmodule

// >>> sim/tb_interrupt_driven_transfer_controller.sv
/* Self-checking bench of the transfer controller in all three modes.
 * Assumes the memory model stands on the system bus. */
`timescale 1ns/1ps
module tb_interrupt_driven_transfer_controller
	import itc_pkg::*;
;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic               software_done_interrupt, sys_ack, slow, c, q, e;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, sys_rdata, r;
	logic [3:0]         pstrb;
	logic [NUM_SRC-1:0] src_request, src_clear, cpu_request;
	itc_bus_req_t       sys_out;
	int                 num_errors, checks, cycles;

	itc_transfer_controller i_itc_transfer_controller (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .src_request(src_request), .src_clear(src_clear),
		.cpu_request(cpu_request), .software_done_interrupt(software_done_interrupt),
		.sys_out(sys_out), .sys_rdata(sys_rdata), .sys_ack(sys_ack));
	itc_mem_model i_itc_mem_model (.pclk(pclk), .presetn(presetn), .slow(slow),
		.sys_out(sys_out), .sys_rdata(sys_rdata), .sys_ack(sys_ack));

	always #5 pclk = ~pclk;

	task automatic end_of_test();
		$display("errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic mchk(input logic [31:0] a, input logic [31:0] exp);
		chk(i_itc_mem_model.mem[a[31:2]], exp);
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic desc(input logic [31:0] a, w0, w1, w2, w3);
		i_itc_mem_model.poke(a, SZ_LONG, w0);
		i_itc_mem_model.poke(a + 32'h4, SZ_LONG, w1);
		i_itc_mem_model.poke(a + 32'h8, SZ_LONG, w2);
		i_itc_mem_model.poke(a + 32'hC, SZ_LONG, w3);
	endtask
	task automatic fire(input int s);
		@(posedge pclk);
		src_request[s] <= 1'b1;
		{c, q} = 2'b00;
		repeat (400) begin
			@(negedge pclk);
			if ((src_clear[s] | cpu_request[s]) === 1'b1) begin
				{c, q} = {src_clear[s], cpu_request[s]};
				break;
			end
		end
		@(posedge pclk);
		src_request[s] <= 1'b0;
	endtask
	task automatic t_normal();
		desc(32'h100, 32'hA200_0002, 32'hDEAD_BEEF, 32'h1000, 32'h2000);
		fire(0);
		chk(32'({c, q}), 32'h2);
		mchk(32'h100, 32'hA200_0001);
		mchk(32'h108, 32'h1004);
		mchk(32'h10C, 32'h2004);
		mchk(32'h2000, 32'h1122_3344);
		fire(0);
		chk(32'({c, q}), 32'h1);
		mchk(32'h100, 32'hA200_0000);
		mchk(32'h104, 32'hDEAD_BEEF);
		mchk(32'h2004, 32'h5566_7788);
		apb(REG_ENABLE, 1'b0, 32'h0);
		chk(r, 32'h6);
	endtask

	task automatic t_repeat();
		desc(32'h110, 32'hA400_0201, 32'h3000, 32'h1000, 32'h3004);
		fire(1);
		chk(32'({c, q}), 32'h2);
		mchk(32'h110, 32'hA400_0202);
		mchk(32'h118, 32'h1001);
		mchk(32'h11C, 32'h3000);
		mchk(32'h3004, 32'h44);
	endtask

	task automatic t_block();
		desc(32'h120, 32'hA980_0001, 32'h2, 32'h1000, 32'h4000);
		slow <= 1'b1;
		fire(2);
		chk(32'({c, q}), 32'h1);
		mchk(32'h120, 32'hA980_0000);
		mchk(32'h124, 32'h2);
		mchk(32'h128, 32'h1000);
		mchk(32'h12C, 32'h4004);
		mchk(32'h4000, 32'h1122_3344);
	endtask

	task automatic t_soft();
		desc(32'h130, 32'hE200_0001, 32'h0, 32'h1004, 32'h5000);
		apb(REG_SWCTL, 1'b0, 32'h0);
		chk(32'(r[SW_FLAG]), 32'h0);
		apb(REG_SWCTL, 1'b1, 32'h0000_0120);
		repeat (60) begin
			apb(REG_STATUS, 1'b0, 32'h0);
			if (r[4] === 1'b0) begin
				break;
			end
		end
		apb(REG_STATUS, 1'b0, 32'h0);
		chk(32'(r[4]), 32'h0);
		mchk(32'h130, 32'hE200_0000);
		mchk(32'h138, 32'h1000);
		mchk(32'h5000, 32'h5566_7788);
		apb(REG_SWCTL, 1'b1, 32'h0000_0020);
		chk(32'(r[SW_DONE:SW_FLAG]), 32'h3);
		apb(REG_SWCTL, 1'b0, 32'h0);
		chk(32'({software_done_interrupt, r[SW_FLAG]}), 32'h0);
		apb(12'h010, 1'b0, 32'h0);
		chk({r[31:1], e}, 32'h0000_0001);
	endtask

	initial begin
		{pclk, presetn, psel, penable, pwrite, slow} = 6'h00;
		{paddr, pwdata, src_request} = '0;
		pstrb = 4'hF;
		{num_errors, checks, cycles} = '0;
		i_itc_mem_model.poke(32'h1000, SZ_LONG, 32'h1122_3344);
		i_itc_mem_model.poke(32'h1004, SZ_LONG, 32'h5566_7788);
		i_itc_mem_model.poke(32'h400, SZ_WORD, 32'h0100);
		i_itc_mem_model.poke(32'h402, SZ_WORD, 32'h0110);
		i_itc_mem_model.poke(32'h404, SZ_WORD, 32'h0120);
		i_itc_mem_model.poke(32'h420, SZ_WORD, 32'h0130);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(REG_BASE, 1'b1, 32'h0);
		apb(REG_ENABLE, 1'b1, 32'h7);
		t_normal();
		t_repeat();
		t_block();
		t_soft();
		end_of_test();
	end
endmodule
